// [src/edge_event_defs.svh]
// Constants of the edge/event line controller: sizes, offsets, reset values.
// Assumes inclusion by bare name; definitions only.
`ifndef EDGE_EVENT_DEFS_SVH
`define EDGE_EVENT_DEFS_SVH

// ============================================================
// Sizes
`define EE_NUM_LINES    23
`define EE_NUM_EXT      16
`define EE_NUM_INT      7
`define EE_NUM_PINS     114
`define EE_SEL_W        7
`define EE_ADDR_W       8
`define EE_DATA_W       32
`define EE_SEL_PER_REG  4
`define EE_SEL_FIELD_W  8

// ============================================================
// Register byte offsets
`define EE_OFF_IMASK    8'h00
`define EE_OFF_EMASK    8'h04
`define EE_OFF_RISE     8'h08
`define EE_OFF_FALL     8'h0c
`define EE_OFF_PEND     8'h10
`define EE_OFF_SEL0     8'h14
`define EE_OFF_SEL1     8'h18
`define EE_OFF_SEL2     8'h1c
`define EE_OFF_SEL3     8'h20

// ============================================================
// Reset values
`define EE_LINES_RST    23'h000000
`define EE_ACK_RST      23'h7fffff
`define EE_SEL_RST      7'h00
`define EE_DATA_ZERO    32'h00000000

`endif

// [src/edge_event_pkg.sv]
// Types shared by the edge/event line controller modules.
// Assumes edge_event_defs.svh is on the include path.
`default_nettype none
`include "edge_event_defs.svh"

package edge_event_pkg;
    // ============================================================
    // Types
    typedef logic [`EE_NUM_LINES-1:0] line_vec_t;
    typedef logic [`EE_SEL_W-1:0]     pin_sel_t;
    typedef logic [`EE_DATA_W-1:0]    word_t;
    typedef logic [`EE_ADDR_W-1:0]    addr_t;
endpackage

`default_nettype wire

// [src/edge_capture_if.sv]
// Carrier between the core logic and the asynchronous edge catchers.
// Assumes both ends sit on the same core clock.
`default_nettype none

interface edge_capture_if;
    import edge_event_pkg::*;
    line_vec_t src;       // Raw line levels, may be async
    line_vec_t ack_rise;  // Clears the rise catchers while high
    line_vec_t ack_fall;  // Clears the fall catchers while high
    line_vec_t rise_seen; // Synchronised rise catch
    line_vec_t fall_seen; // Synchronised fall catch

    modport catcher (input src, input ack_rise, input ack_fall,
                     output rise_seen, output fall_seen);
    modport core (output src, output ack_rise, output ack_fall,
                  input rise_seen, input fall_seen);
endinterface

`default_nettype wire

// [src/edge_catcher.sv]
// Per-line edge catchers clocked by the line itself, plus two-flop syncs.
// Assumes the core holds ack high until the synced catch drops again.
`default_nettype none
`include "edge_event_defs.svh"

module edge_catcher
    import edge_event_pkg::*;
(
    input  wire logic            i_core_clk, // Core clock
    input  wire logic            i_rst_n,    // Synchronous reset, active low
    edge_capture_if.catcher      cap         // Lines in, catches out
);

    line_vec_t rise_meta_r;
    line_vec_t rise_sync_r;
    line_vec_t fall_meta_r;
    line_vec_t fall_sync_r;
    line_vec_t rise_hold;
    line_vec_t fall_hold;

    // ============================================================
    // Catchers: the line is the clock, so pulses under a core period stick
    for (genvar g = 0; g < `EE_NUM_LINES; g++) begin : g_line
        logic rise_q;
        logic fall_q;

        // Async clear takes a constant; ack comes from a core flop
        always_ff @(posedge cap.src[g] or posedge cap.ack_rise[g]) begin
            if (cap.ack_rise[g]) begin
                rise_q <= 1'b0;
            end else begin
                rise_q <= 1'b1;
            end
        end

        always_ff @(negedge cap.src[g] or posedge cap.ack_fall[g]) begin
            if (cap.ack_fall[g]) begin
                fall_q <= 1'b0;
            end else begin
                fall_q <= 1'b1;
            end
        end

        assign rise_hold[g] = rise_q;
        assign fall_hold[g] = fall_q;

        // Ack must knock the synced catch down within the sync depth
        chk_ack_clears_rise: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
            $rose(cap.ack_rise[g]) |-> ##[1:3] !cap.rise_seen[g])
            else $error("rise catch not cleared by ack");
    end

    // ============================================================
    // Two-flop synchronisers into the core domain
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rise_meta_r <= `EE_LINES_RST;
            rise_sync_r <= `EE_LINES_RST;
            fall_meta_r <= `EE_LINES_RST;
            fall_sync_r <= `EE_LINES_RST;
        end else begin
            rise_meta_r <= rise_hold;
            rise_sync_r <= rise_meta_r;
            fall_meta_r <= fall_hold;
            fall_sync_r <= fall_meta_r;
        end
    end

    assign cap.rise_seen = rise_sync_r;
    assign cap.fall_seen = fall_sync_r;

endmodule

`default_nettype wire

// [src/edge_event_line_controller.sv]
// Edge/event line controller: 23 edge lines, pin selectors, registers.
// Assumes a one-cycle strobe register port and a single core clock.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`default_nettype none
`include "edge_event_defs.svh"

module edge_event_line_controller
    import edge_event_pkg::*;
(
    input  wire logic                   i_core_clk, // Core clock, 200 MHz
    input  wire logic                   i_rst_n,    // Synchronous reset, active low
    input  wire logic [`EE_NUM_PINS-1:0] i_pins,     // General-purpose pin levels
    input  wire logic [`EE_NUM_INT-1:0]  i_int_lines, // Internal request lines
    input  wire addr_t                  i_addr,     // Register byte address
    input  wire word_t                  i_wdata,    // Write data
    input  wire logic                   i_wr,       // Write strobe
    input  wire logic                   i_rd,       // Read strobe
    output var  word_t                  o_rdata,    // Read data, cycle after strobe
    output var  logic                   o_irq,      // Any unmasked pending line
    output var  line_vec_t              o_line_irq, // Per-line request to irq ctrl
    output var  line_vec_t              o_event     // Per-line event pulse
);

    edge_capture_if cap_if ();

    // ============================================================
    // Register state
    line_vec_t imask_r;
    line_vec_t imask_nxt;
    line_vec_t emask_r;
    line_vec_t emask_nxt;
    line_vec_t rise_en_r;
    line_vec_t rise_en_nxt;
    line_vec_t fall_en_r;
    line_vec_t fall_en_nxt;
    line_vec_t pend_r;
    line_vec_t pend_nxt;
    pin_sel_t  sel_r   [`EE_NUM_EXT];
    pin_sel_t  sel_nxt [`EE_NUM_EXT];
    word_t     rdata_nxt;

    // ============================================================
    // Handshake and output state
    line_vec_t ack_rise_r;
    line_vec_t ack_rise_nxt;
    line_vec_t ack_fall_r;
    line_vec_t ack_fall_nxt;
    line_vec_t line_irq_nxt;
    line_vec_t event_nxt;
    logic      irq_nxt;

    line_vec_t rise_new;
    line_vec_t fall_new;
    line_vec_t det;
    line_vec_t clr;
    logic      wr_pend;

    // ============================================================
    // Pin selectors: out-of-range codes give a quiet low line
    for (genvar g = 0; g < `EE_NUM_EXT; g++) begin : g_sel
        assign cap_if.src[g] = (sel_r[g] < `EE_SEL_W'(`EE_NUM_PINS)) ?
                               i_pins[sel_r[g]] : 1'b0;

        chk_mux_range: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
            (sel_r[g] >= `EE_SEL_W'(`EE_NUM_PINS)) |-> !cap_if.src[g])
            else $error("unmapped pin code drives a line");
    end

    // Internal lines bypass the selectors
    assign cap_if.src[`EE_NUM_LINES-1:`EE_NUM_EXT] = i_int_lines;
    assign cap_if.ack_rise = ack_rise_r;
    assign cap_if.ack_fall = ack_fall_r;

    edge_catcher u_catcher (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .cap        (cap_if.catcher)
    );

    // ============================================================
    // Edge detection: first cycle of a synced catch, before ack rises
    assign rise_new = cap_if.rise_seen & ~ack_rise_r;
    assign fall_new = cap_if.fall_seen & ~ack_fall_r;
    // Both enables set gives both edges
    assign det = (rise_new & rise_en_r) | (fall_new & fall_en_r);

    // Ack follows the synced catch: a four-phase handshake per catcher.
    // Edges in the few cycles the catcher is held clear are missed.
    always_comb begin
        ack_rise_nxt = cap_if.rise_seen;
        ack_fall_nxt = cap_if.fall_seen;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ack_rise_r <= `EE_ACK_RST;
            ack_fall_r <= `EE_ACK_RST;
        end else begin
            ack_rise_r <= ack_rise_nxt;
            ack_fall_r <= ack_fall_nxt;
        end
    end

    // ============================================================
    // Register writes and pending bits
    assign wr_pend = i_wr && (i_addr == `EE_OFF_PEND);
    assign clr = wr_pend ? i_wdata[`EE_NUM_LINES-1:0] : `EE_LINES_RST;

    always_comb begin
        imask_nxt   = imask_r;
        emask_nxt   = emask_r;
        rise_en_nxt = rise_en_r;
        fall_en_nxt = fall_en_r;
        for (int s = 0; s < `EE_NUM_EXT; s++) begin
            sel_nxt[s] = sel_r[s];
        end
        if (i_wr) begin
            unique case (i_addr)
                `EE_OFF_IMASK: imask_nxt   = i_wdata[`EE_NUM_LINES-1:0];
                `EE_OFF_EMASK: emask_nxt   = i_wdata[`EE_NUM_LINES-1:0];
                `EE_OFF_RISE:  rise_en_nxt = i_wdata[`EE_NUM_LINES-1:0];
                `EE_OFF_FALL:  fall_en_nxt = i_wdata[`EE_NUM_LINES-1:0];
                `EE_OFF_SEL0, `EE_OFF_SEL1, `EE_OFF_SEL2, `EE_OFF_SEL3: begin
                    for (int k = 0; k < `EE_SEL_PER_REG; k++) begin
                        sel_nxt[(int'(i_addr - `EE_OFF_SEL0) / 4) * `EE_SEL_PER_REG + k] =
                            i_wdata[k*`EE_SEL_FIELD_W +: `EE_SEL_W];
                    end
                end
                default: ;
            endcase
        end
        // Set beats clear so a same-cycle edge is never lost
        pend_nxt = (pend_r & ~clr) | det;
    end

    // ============================================================
    // Outputs: line requests from next pending and mask, event from det and emask_r, all straight off flops
    always_comb begin
        line_irq_nxt = pend_nxt & imask_nxt;
        irq_nxt      = |line_irq_nxt;
        event_nxt    = det & emask_r;
    end

    // Read mux: unmapped addresses and idle cycles read as zero
    always_comb begin
        rdata_nxt = `EE_DATA_ZERO;
        if (i_rd) begin
            unique case (i_addr)
                `EE_OFF_IMASK: rdata_nxt = word_t'(imask_r);
                `EE_OFF_EMASK: rdata_nxt = word_t'(emask_r);
                `EE_OFF_RISE:  rdata_nxt = word_t'(rise_en_r);
                `EE_OFF_FALL:  rdata_nxt = word_t'(fall_en_r);
                `EE_OFF_PEND:  rdata_nxt = word_t'(pend_r);
                `EE_OFF_SEL0, `EE_OFF_SEL1, `EE_OFF_SEL2, `EE_OFF_SEL3: begin
                    for (int k = 0; k < `EE_SEL_PER_REG; k++) begin
                        rdata_nxt[k*`EE_SEL_FIELD_W +: `EE_SEL_W] =
                            sel_r[(int'(i_addr - `EE_OFF_SEL0) / 4) * `EE_SEL_PER_REG + k];
                    end
                end
                default: rdata_nxt = `EE_DATA_ZERO;
            endcase
        end
    end

    // ============================================================
    // Register file and output flops
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            imask_r    <= `EE_LINES_RST;
            emask_r    <= `EE_LINES_RST;
            rise_en_r  <= `EE_LINES_RST;
            fall_en_r  <= `EE_LINES_RST;
            pend_r     <= `EE_LINES_RST;
            for (int s = 0; s < `EE_NUM_EXT; s++) begin
                sel_r[s] <= `EE_SEL_RST;
            end
            o_rdata    <= `EE_DATA_ZERO;
            o_irq      <= 1'b0;
            o_line_irq <= `EE_LINES_RST;
            o_event    <= `EE_LINES_RST;
        end else begin
            imask_r    <= imask_nxt;
            emask_r    <= emask_nxt;
            rise_en_r  <= rise_en_nxt;
            fall_en_r  <= fall_en_nxt;
            pend_r     <= pend_nxt;
            for (int s = 0; s < `EE_NUM_EXT; s++) begin
                sel_r[s] <= sel_nxt[s];
            end
            o_rdata    <= rdata_nxt;
            o_irq      <= irq_nxt;
            o_line_irq <= line_irq_nxt;
            o_event    <= event_nxt;
        end
    end

    // ============================================================
    // Checks
    chk_pend_set_on_edge: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        |det |=> ((pend_r & $past(det)) == $past(det)))
        else $error("edge did not set its pending bit");

    chk_pend_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !wr_pend |=> ((pend_r & $past(pend_r)) == $past(pend_r)))
        else $error("pending bit dropped without a clear write");

    chk_pend_has_cause: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ##1 ((pend_r & ~$past(pend_r) & ~$past(det)) == `EE_LINES_RST))
        else $error("pending bit set with no edge");

    chk_rise_only_sel: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        |(rise_new & ~rise_en_r & ~fall_new & ~pend_r) |=>
        ((pend_r & $past(rise_new & ~rise_en_r & ~fall_new & ~pend_r)) == `EE_LINES_RST))
        else $error("disabled rising edge set a pending bit");

    chk_line_irq_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_line_irq == (pend_r & imask_r))
        else $error("line request does not follow pending and mask");

    chk_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_irq == (|(pend_r & imask_r)))
        else $error("interrupt output disagrees with pending bits");

    chk_event_masked: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ##1 ((o_event & ~$past(emask_r)) == `EE_LINES_RST))
        else $error("event pulse on a masked line");

    chk_event_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        |o_event |=> ((o_event & $past(o_event)) == `EE_LINES_RST))
        else $error("event held longer than one cycle");

    chk_pend_readback: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == `EE_OFF_PEND) |=>
        (o_rdata == word_t'($past(pend_r))))
        else $error("pending read does not show pending bits");

endmodule

`default_nettype wire

// [verif/pin_partner.sv]
// Far-side model: drives pin levels and internal lines, counts event pulses.
// Assumes the block catches pin edges asynchronously; events are one-cycle pulses.
`default_nettype none
`include "edge_event_defs.svh"

module pin_partner
    import edge_event_pkg::*;
(
    input  wire logic                    i_core_clk, // Core clock
    input  wire line_vec_t               i_event,    // Event pulses from the block
    output var  logic [`EE_NUM_PINS-1:0] o_pins,     // Pin levels, idle low
    output var  logic [`EE_NUM_INT-1:0]  o_int_lines // Internal line levels
);
    timeunit 1ns;
    timeprecision 100ps;

    int unsigned evt_cnt [`EE_NUM_LINES];

    // ============================================================
    // Pin and line drivers
    initial begin
        o_pins      = '0;
        o_int_lines = '0;
    end

    // High pulse of 2 ns, well under one 5 ns core period
    task automatic pulse(input int idx);
        o_pins[idx] = 1'b1;
        #2;
        o_pins[idx] = 1'b0;
    endtask

    task automatic set_pin(input int idx, input logic lvl);
        o_pins[idx] = lvl;
    endtask

    task automatic set_int(input int idx, input logic lvl);
        o_int_lines[idx] = lvl;
    endtask

    // ============================================================
    // Event counting, one count per pulse cycle
    always @(posedge i_core_clk) begin
        for (int i = 0; i < `EE_NUM_LINES; i++) begin
            if (i_event[i] === 1'b1) begin
                evt_cnt[i] <= evt_cnt[i] + 1;
            end
        end
    end
endmodule

`default_nettype wire

// [verif/edge_event_line_controller_test.sv]
// Bench for the edge/event line controller: register port, pins, internal lines.
// Assumes one 200 MHz core clock and the pin partner model beside the block.
`default_nettype none
`include "edge_event_defs.svh"

module edge_event_line_controller_test
    import edge_event_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                    i_core_clk;
    logic                    i_rst_n;
    logic                    i_wr;
    logic                    i_rd;
    addr_t                   i_addr;
    word_t                   i_wdata;
    word_t                   o_rdata;
    logic                    o_irq;
    line_vec_t               o_line_irq;
    line_vec_t               o_event;
    logic [`EE_NUM_PINS-1:0] pins;
    logic [`EE_NUM_INT-1:0]  ints;
    word_t                   rd_val;
    int                      error_cnt;
    int                      num_checks;
    int                      cyc;

    edge_event_line_controller u_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pins(pins), .i_int_lines(ints),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq), .o_line_irq(o_line_irq), .o_event(o_event));

    pin_partner u_far (
        .i_core_clk(i_core_clk), .i_event(o_event), .o_pins(pins), .o_int_lines(ints));

    // ============================================================
    // Clock and timeout; 5000 cycles is far beyond the whole sequence
    initial i_core_clk = 1'b0;
    always #2.5 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    // ============================================================
    // Helpers
    function automatic logic bad(input logic ok);
        num_checks++;
        return ok !== 1'b1;
    endfunction

    task automatic fail(input string msg);
        error_cnt++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Strobes drop one edge later, so back-to-back calls never clash
    task automatic wr(input addr_t a, input word_t d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input addr_t a);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic pend_is(input line_vec_t e);
        rd(`EE_OFF_PEND);
        if (bad(rd_val === {9'h000, e})) fail("pending bits differ");
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        for (int k = 0; k <= 9; k++) begin
            rd(8'(k * 4));
            if (bad(rd_val === `EE_DATA_ZERO)) fail("register not zero");
        end
        if (bad(o_irq === 1'b0 && o_line_irq === `EE_LINES_RST)) fail("irq after reset");
        // Unmapped codes on lines 12-15; only the low 7 bits of each field stick
        wr(`EE_OFF_SEL3, 32'hffffffff);
        rd(`EE_OFF_SEL3);
        if (bad(rd_val === 32'h7f7f7f7f)) fail("selector field width");
    endtask

    // Narrow pulse on selected pin 5; pin 4 must not reach line 0
    task automatic t_narrow_rise();
        wr(`EE_OFF_SEL0, 32'h00007105);
        wr(`EE_OFF_RISE, 32'h00000001);
        wr(`EE_OFF_FALL, 32'h00000002);
        wr(`EE_OFF_IMASK, 32'h00000003);
        wr(`EE_OFF_EMASK, 32'h00000003);
        u_far.pulse(4);
        idle(6);
        pend_is(23'h000000);
        u_far.pulse(5);
        idle(6);
        if (bad(u_far.evt_cnt[0] === 1)) fail("no event on line 0");
        if (bad(o_line_irq === 23'h000001 && o_irq === 1'b1)) fail("line 0 irq");
        pend_is(23'h000001);
    endtask

    // Line 1 on pin 113 reacts to the falling edge only
    task automatic t_fall_only();
        u_far.set_pin(113, 1'b1);
        idle(8);
        pend_is(23'h000001);
        u_far.set_pin(113, 1'b0);
        idle(6);
        pend_is(23'h000003);
        rd(`EE_OFF_SEL0);
        if (bad(rd_val === 32'h00007105)) fail("selector readback");
        if (bad(u_far.evt_cnt[1] === 1)) fail("no event on line 1");
    endtask

    task automatic t_clear();
        wr(`EE_OFF_PEND, 32'h00000000);
        pend_is(23'h000003);
        wr(`EE_OFF_PEND, 32'h00000001);
        pend_is(23'h000002);
        if (bad(o_line_irq === 23'h000002)) fail("line 0 irq kept");
        wr(`EE_OFF_PEND, 32'h00000002);
        pend_is(23'h000000);
        if (bad(o_irq === 1'b0)) fail("irq kept after clear");
    endtask

    // Internal line 16 on both edges
    task automatic t_both_int();
        wr(`EE_OFF_RISE, 32'h00010001);
        wr(`EE_OFF_FALL, 32'h00010002);
        wr(`EE_OFF_IMASK, 32'h00010003);
        wr(`EE_OFF_EMASK, 32'h00010003);
        u_far.set_int(0, 1'b1);
        idle(6);
        pend_is(23'h010000);
        wr(`EE_OFF_PEND, 32'h00010000);
        u_far.set_int(0, 1'b0);
        idle(6);
        pend_is(23'h010000);
        if (bad(u_far.evt_cnt[16] === 2)) fail("line 16 events");
    endtask

    // Masking line 16 leaves line 0 forwarding
    task automatic t_mask();
        wr(`EE_OFF_IMASK, 32'h00000003);
        idle(1);
        if (bad(o_line_irq === 23'h000000 && o_irq === 1'b0)) fail("mask ignored");
        u_far.pulse(5);
        idle(6);
        if (bad(o_line_irq === 23'h000001 && o_irq === 1'b1)) fail("line 0 hit");
        pend_is(23'h010001);
        wr(`EE_OFF_IMASK, 32'h00010003);
        idle(1);
        if (bad(o_line_irq === 23'h010001)) fail("unmask lost");
    endtask

    // ============================================================
    // Main sequence
    initial begin
        i_rst_n    = 1'b0;
        i_wr       = 1'b0;
        i_rd       = 1'b0;
        i_addr     = 8'h00;
        i_wdata    = `EE_DATA_ZERO;
        error_cnt  = 0;
        num_checks = 0;
        cyc        = 0;
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_narrow_rise();
        t_fall_only();
        t_clear();
        t_both_int();
        t_mask();
        conclude();
    end
endmodule

`default_nettype wire
